// [rtl/reset_sequencer.sv]
// reset sequencer: power-on delay, reset pin drive and sample,
// reset cause and vector, software watchdog control
// assumes i_rst is the power-on reset and the clock is the E clock;
// the reset pin is open drain and pulled high outside
`timescale 1ns/100ps
`default_nettype none
`include "rst_cfg.svh"

// How it works
// - power-on and pin resets share one vector; the rest have their own.
// - any reset holds the cpu at once and reloads vector and control bits.
// - after power-on the block waits 4064 cycles before leaving reset.
// - a pin still low when that wait ends holds reset until it is high.
// - any reset condition but power-on pulls the pin low for four cycles, then lets go.
// - two cycles after release a low pin means external, high internal.
// - an enabled watchdog not serviced in time starts a system reset.
// - the disable bit sets watchdog enable, taken only at a system reset.
// - special modes start with watchdog resets inhibited until cleared.
// - timeout is clock over 2^15, then over 1, 4, 16 or 64 by rate.
// - reset clears the rate select, giving the shortest timeout.
// - normal modes take one rate write, only in the first 64 cycles.
// - work may fall between the writes, but both must land in time.
// - disable bit 0 lets a timeout force reset, 1 stops it.
// - vectors FFFE, FFFC, FFFA in normal mode; BFFE, BFFC, BFFA special.
module reset_sequencer
    import rst_pkg::*;
#(
    parameter int WD_BASE_DIV = `RST_WD_BASE_DIV
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    output logic o_reset_pin_o,
    output logic o_reset_pin_oe,
    input wire logic i_clkmon_fail,
    input wire logic i_special_mode,
    input wire logic i_watchdog_disable_bit,
    input wire logic i_service_wr,
    input wire logic [7:0] i_service_data,
    input wire logic i_rate_wr,
    input wire logic [1:0] i_rate_data,
    input wire logic i_inhibit_wr,
    input wire logic i_inhibit_data,
    output logic o_cpu_reset,
    output logic [15:0] o_reset_vector,
    output logic [1:0] o_reset_cause,
    output logic o_watchdog_enabled,
    output logic [1:0] o_watchdog_rate_select,
    output logic o_reset_inhibit_bit
);

    wd_if wd ();

    // ========================================
    // pin synchronisers
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic pin_high;
    logic clkmon;
    logic special;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_reg <= 3'h1;
            sync2_reg <= 3'h1;
        end else begin
            sync1_reg <= {i_special_mode, i_clkmon_fail, i_reset_pin_n};
            sync2_reg <= sync1_reg;
        end
    end

    assign pin_high = sync2_reg[0];
    assign clkmon = sync2_reg[1];
    assign special = sync2_reg[2];

    // ========================================
    // reset sequence
    seq_state_e state_reg;
    seq_state_e state_next;
    reset_cause_e cause_reg;
    reset_cause_e cause_next;
    logic [11:0] cnt_reg;
    logic [11:0] cnt_next;
    logic oe_reg;
    logic cpu_reset_reg;
    logic [15:0] vector_reg;
    logic [15:0] vector_next;

    always_comb begin
        state_next = state_reg;
        cause_next = cause_reg;
        cnt_next = cnt_reg + 12'h001;
        case (state_reg)
            ST_POR: begin
                if (cnt_reg == `RST_POR_CYCLES - 12'h001) begin
                    cnt_next = 12'h000;
                    state_next = pin_high ? ST_RUN : ST_HOLD;
                end
            end
            ST_DRIVE: begin
                if (cnt_reg == `RST_DRIVE_CYCLES - 12'h001) begin
                    cnt_next = 12'h000;
                    state_next = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                // the pin reaches us through two flops, so wait them out
                if (cnt_reg == `RST_SAMPLE_CYCLES + `RST_SYNC_STAGES -
                        12'h001) begin
                    cnt_next = 12'h000;
                    if (!pin_high) begin
                        cause_next = CAUSE_PIN;
                        state_next = ST_HOLD;
                    end else begin
                        state_next = ST_RUN;
                    end
                end
            end
            ST_HOLD: begin
                cnt_next = 12'h000;
                if (pin_high) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                cnt_next = 12'h000;
                if (wd.timeout) begin
                    cause_next = CAUSE_WD;
                    state_next = ST_DRIVE;
                end else if (clkmon) begin
                    cause_next = CAUSE_CLKMON;
                    state_next = ST_DRIVE;
                end else if (!pin_high) begin
                    cause_next = CAUSE_PIN;
                    state_next = ST_DRIVE;
                end
            end
            default: begin
                cnt_next = 12'h000;
                state_next = ST_POR;
            end
        endcase
        case (cause_next)
            CAUSE_CLKMON: vector_next = special ?
                `RST_VEC_CLKMON_SPEC : `RST_VEC_CLKMON_NORM;
            CAUSE_WD: vector_next = special ?
                `RST_VEC_WD_SPEC : `RST_VEC_WD_NORM;
            default: vector_next = special ?
                `RST_VEC_PIN_SPEC : `RST_VEC_PIN_NORM;
        endcase
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_POR;
            cause_reg <= CAUSE_PIN;
            cnt_reg <= 12'h000;
            oe_reg <= 1'b0;
            cpu_reset_reg <= 1'b1;
            vector_reg <= `RST_VEC_PIN_NORM;
        end else begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            cnt_reg <= cnt_next;
            oe_reg <= (state_next == ST_DRIVE);
            cpu_reset_reg <= (state_next != ST_RUN);
            vector_reg <= vector_next;
        end
    end

    // ========================================
    // watchdog control bits
    logic in_reset;
    logic dis_reg;
    logic dis_next;
    logic inhibit_reg;
    logic inhibit_next;
    logic [1:0] rate_reg;
    logic [1:0] rate_next;
    logic rate_done_reg;
    logic rate_done_next;
    logic [6:0] win_reg;
    logic [6:0] win_next;
    logic enable_reg;

    assign in_reset = (state_reg != ST_RUN);

    always_comb begin
        dis_next = dis_reg;
        inhibit_next = inhibit_reg;
        rate_next = rate_reg;
        rate_done_next = rate_done_reg;
        win_next = win_reg;
        if (in_reset) begin
            dis_next = i_watchdog_disable_bit;
            inhibit_next = special;
            rate_next = `RST_RATE_RESET;
            rate_done_next = 1'b0;
            win_next = 7'h00;
        end else begin
            if (win_reg != `RST_RATE_WINDOW) begin
                win_next = win_reg + 7'h01;
            end
            if (i_inhibit_wr && special) begin
                inhibit_next = i_inhibit_data;
            end
            if (i_rate_wr && (special || (!rate_done_reg &&
                    win_reg != `RST_RATE_WINDOW))) begin
                rate_next = i_rate_data;
                rate_done_next = 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            dis_reg <= 1'b0;
            inhibit_reg <= 1'b0;
            rate_reg <= `RST_RATE_RESET;
            rate_done_reg <= 1'b0;
            win_reg <= 7'h00;
            enable_reg <= 1'b0;
        end else begin
            dis_reg <= dis_next;
            inhibit_reg <= inhibit_next;
            rate_reg <= rate_next;
            rate_done_reg <= rate_done_next;
            win_reg <= win_next;
            enable_reg <= !dis_next && !inhibit_next;
        end
    end

    assign wd.sys_rst = in_reset;
    assign wd.enable = enable_reg;
    assign wd.rate = rate_reg;
    assign wd.service_wr = i_service_wr && !in_reset;
    assign wd.service_data = i_service_data;

    software_watchdog #(
        .BASE_DIV(WD_BASE_DIV)
    ) u_watchdog (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .wd(wd.dog)
    );

    // ========================================
    // outputs
    logic pin_o_reg;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_o_reg <= 1'b0;
        end else begin
            pin_o_reg <= 1'b0;
        end
    end

    assign o_reset_pin_o = pin_o_reg;
    assign o_reset_pin_oe = oe_reg;
    assign o_cpu_reset = cpu_reset_reg;
    assign o_reset_vector = vector_reg;
    assign o_reset_cause = cause_reg;
    assign o_watchdog_enabled = enable_reg;
    assign o_watchdog_rate_select = rate_reg;
    assign o_reset_inhibit_bit = inhibit_reg;

endmodule

`default_nettype wire

// [rtl/rst_cfg.svh]
// constants for the reset sequencer and the software watchdog
// assumes the block clock is the bus E clock
`ifndef RST_CFG_SVH
`define RST_CFG_SVH

// power-on settle, pin drive and pin sample times in E-clock cycles
`define RST_POR_CYCLES 12'd4064
`define RST_DRIVE_CYCLES 12'd4
`define RST_SAMPLE_CYCLES 12'd2
`define RST_SYNC_STAGES 12'd2

// rate select write window after reset, in bus cycles
`define RST_RATE_WINDOW 7'd64
`define RST_RATE_RESET 2'h0

// watchdog prescale ahead of the rate divider
`define RST_WD_BASE_DIV 32768

// service register codes
`define RST_SERVICE_ARM 8'h55
`define RST_SERVICE_CLEAR 8'hAA

// reset vectors, normal and special modes
`define RST_VEC_PIN_NORM 16'hFFFE
`define RST_VEC_CLKMON_NORM 16'hFFFC
`define RST_VEC_WD_NORM 16'hFFFA
`define RST_VEC_PIN_SPEC 16'hBFFE
`define RST_VEC_CLKMON_SPEC 16'hBFFC
`define RST_VEC_WD_SPEC 16'hBFFA

`endif

// [rtl/rst_pkg.sv]
// types shared by the reset sequencer and the software watchdog
// assumes rst_cfg.svh supplies the numeric constants
package rst_pkg;

    typedef enum logic [4:0] {
        ST_POR = 5'h01,
        ST_DRIVE = 5'h02,
        ST_SETTLE = 5'h04,
        ST_HOLD = 5'h08,
        ST_RUN = 5'h10
    } seq_state_e;

    typedef enum logic [1:0] {
        CAUSE_PIN = 2'h0,
        CAUSE_CLKMON = 2'h1,
        CAUSE_WD = 2'h2
    } reset_cause_e;

endpackage

// [rtl/wd_if.sv]
// link between the reset sequencer and its software watchdog
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none

interface wd_if;
    logic sys_rst;
    logic enable;
    logic [1:0] rate;
    logic service_wr;
    logic [7:0] service_data;
    logic timeout;

    modport ctrl (
        output sys_rst,
        output enable,
        output rate,
        output service_wr,
        output service_data,
        input timeout
    );

    modport dog (
        input sys_rst,
        input enable,
        input rate,
        input service_wr,
        input service_data,
        output timeout
    );
endinterface

`default_nettype wire

// [rtl/software_watchdog.sv]
// free-running software watchdog with two-write service sequence
// assumes control comes from the reset sequencer over wd_if
`timescale 1ns/100ps
`default_nettype none
`include "rst_cfg.svh"

module software_watchdog
    import rst_pkg::*;
#(
    parameter int BASE_DIV = `RST_WD_BASE_DIV
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    wd_if.dog wd
);

    logic [21:0] cnt_reg;
    logic [21:0] cnt_next;
    logic arm_reg;
    logic arm_next;
    logic timeout_reg;
    logic timeout_next;
    logic [21:0] limit;
    logic serviced;

    // ========================================
    // timeout period and service sequence
    always_comb begin
        limit = 22'(BASE_DIV) << {wd.rate, 1'b0};
        serviced = wd.service_wr && arm_reg &&
            (wd.service_data == `RST_SERVICE_CLEAR);
        arm_next = arm_reg;
        if (wd.sys_rst) begin
            arm_next = 1'b0;
        end else if (wd.service_wr) begin
            if (wd.service_data == `RST_SERVICE_ARM) begin
                arm_next = 1'b1;
            end else if (wd.service_data == `RST_SERVICE_CLEAR) begin
                arm_next = 1'b0;
            end
        end
        timeout_next = 1'b0;
        if (wd.sys_rst || serviced) begin
            cnt_next = 22'h000000;
        // compare above too, so a shortened limit cannot be skipped past
        end else if (cnt_reg >= limit - 22'h000001) begin
            cnt_next = 22'h000000;
            timeout_next = wd.enable;
        end else begin
            cnt_next = cnt_reg + 22'h000001;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            cnt_reg <= 22'h000000;
            arm_reg <= 1'b0;
            timeout_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            arm_reg <= arm_next;
            timeout_reg <= timeout_next;
        end
    end

    assign wd.timeout = timeout_reg;

endmodule

`default_nettype wire

// [bench/reset_pin_partner.sv]
// external reset supervisor on the open-drain reset pin
// assumes a pull-up on the wire
`timescale 1ns/100ps
`default_nettype none
module reset_pin_partner (
    input wire logic i_oe,
    input wire logic i_hold,
    output logic o_pin_n
);
    // wire low while either side pulls it, else pulled up
    assign o_pin_n = !(i_oe || i_hold);
endmodule
`default_nettype wire

// [bench/reset_sequencer_chk.sv]
// port assertions for the reset sequencer
// assumes one clock and the async power-on reset
`timescale 1ns/100ps
`default_nettype none
module reset_sequencer_chk (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_reset_pin_n,
    input wire logic i_rate_wr,
    input wire logic o_reset_pin_o,
    input wire logic o_reset_pin_oe,
    input wire logic o_cpu_reset,
    input wire logic [15:0] o_reset_vector,
    input wire logic [1:0] o_reset_cause,
    input wire logic [1:0] o_watchdog_rate_select
);
    // ==========================================
    // sequence checks
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    sequence s_drive;
        o_reset_pin_oe [*4] ##1 !o_reset_pin_oe;
    endsequence
    sequence s_gap;
        $fell(o_reset_pin_oe) ##0 o_cpu_reset [*2];
    endsequence
    drive_len_a:
    assert property ($rose(o_reset_pin_oe) |-> s_drive)
        else $error("pin drive length wrong");
    drive_own_a:
    assert property (o_reset_pin_oe |-> o_cpu_reset && !o_reset_pin_o)
        else $error("pin driven outside reset");
    release_gap_a:
    assert property ($fell(o_reset_pin_oe) |-> o_cpu_reset [*2])
        else $error("reset left before sample");
    internal_end_a:
    assert property (s_gap ##1 i_reset_pin_n [*4] |-> !o_cpu_reset)
        else $error("internal reset not ended");
    pin_hold_a:
    assert property ($fell(o_cpu_reset) |-> $past(i_reset_pin_n))
        else $error("reset left with pin low");
    vector_map_a:
    assert property (o_reset_vector[15] && o_reset_vector[13:0] ==
        (o_reset_cause == 2'h1 ? 14'h3FFC :
        o_reset_cause == 2'h2 ? 14'h3FFA : 14'h3FFE))
        else $error("vector does not match cause");
    rate_hold_a:
    assert property (!o_cpu_reset && !$past(o_cpu_reset) &&
        !$past(i_rate_wr) |-> $stable(o_watchdog_rate_select))
        else $error("rate changed without write");
    rate_clear_a:
    assert property ($rose(o_reset_pin_oe) |-> ##1
        o_watchdog_rate_select == 2'h0)
        else $error("rate not cleared by reset");
endmodule
`default_nettype wire

// [bench/reset_sequencer_tb.sv]
// self-checking bench for the reset sequencer
// assumes a short watchdog prescale and a pulled-up reset pin
`timescale 1ns/100ps
`default_nettype none
`include "rst_cfg.svh"
module reset_sequencer_tb
    import rst_pkg::*;
;
    localparam int BASE = 16;
    logic clk, rst, pin_n, pin_o, oe, hold, clkmon, spec, dis;
    logic swr, rwr, iwr, idat, cpu, wden, inh;
    logic [7:0] sdat;
    logic [1:0] rdat, cause, rate, r;
    logic [15:0] vec;
    int err_total, num_checks, oe_cnt, n, cyc = 0;
    reset_sequencer #(.WD_BASE_DIV(BASE)) i_dut (
        .i_ref_clk(clk), .i_rst(rst), .i_reset_pin_n(pin_n),
        .o_reset_pin_o(pin_o), .o_reset_pin_oe(oe),
        .i_clkmon_fail(clkmon), .i_special_mode(spec),
        .i_watchdog_disable_bit(dis), .i_service_wr(swr),
        .i_service_data(sdat), .i_rate_wr(rwr), .i_rate_data(rdat),
        .i_inhibit_wr(iwr), .i_inhibit_data(idat), .o_cpu_reset(cpu),
        .o_reset_vector(vec), .o_reset_cause(cause),
        .o_watchdog_enabled(wden), .o_watchdog_rate_select(rate),
        .o_reset_inhibit_bit(inh)
    );
    reset_pin_partner i_pin (.i_oe(oe), .i_hold(hold), .o_pin_n(pin_n));
    // ==========================================
    // helpers
    function automatic logic [15:0] vec_of(input logic [1:0] c,
        input logic sp);
        logic [15:0] v;
        v = c == CAUSE_PIN ? `RST_VEC_PIN_NORM :
            c == CAUSE_CLKMON ? `RST_VEC_CLKMON_NORM : `RST_VEC_WD_NORM;
        return sp ? v & 16'hBFFF : v;
    endfunction
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk);
            #1;
            oe_cnt += oe;
        end
    endtask
    task automatic chk_v(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr_svc(input logic [7:0] d);
        sdat = d;
        swr = 1;
        tick(1);
        swr = 0;
        tick(1);
    endtask
    task automatic wr_rate(input logic [1:0] d);
        rdat = d;
        rwr = 1;
        tick(1);
        rwr = 0;
        tick(1);
    endtask
    task automatic por(input logic sp, h);
        spec = sp;
        hold = h;
        rst = 1;
        tick(10);
        rst = 0;
        n = 0;
        while (cpu !== 1'b0 && n < 5000) begin
            tick(1);
            n++;
            if (n == 4100) hold = 0;
        end
    endtask
    task automatic seq(input logic [1:0] c, input int w);
        int k;
        n = 0;
        while (oe !== 1'b1 && n < w) begin
            tick(1);
            n++;
        end
        clkmon = 0;
        chk_v("cause", c, cause);
        chk_v("vector", vec_of(c, spec), vec);
        chk_v("cpu_reset", 1, cpu);
        for (k = 0; oe === 1'b1 && k < 9; k++) tick(1);
        chk_v("drive cycles", 4, k);
        tick(8);
        chk_v("held", hold, cpu);
        hold = 0;
        for (k = 0; cpu !== 1'b0 && k < 9; k++) tick(1);
        chk_v("released", 1, k < 9);
    endtask
    // ==========================================
    // stimulus
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            end_of_test();
        end
    end
    initial begin
        {rst, hold, clkmon, spec, dis, swr, rwr, iwr, idat} = '0;
        {sdat, rdat} = '0;
        {err_total, num_checks, oe_cnt} = '0;
        void'($urandom(32'h8837));
        por(0, 1);
        chk_v("pin holds por", 1, n > 4100 && n < 4110);
        r = 2'($urandom_range(3, 1));
        wr_rate(r);
        wr_rate(~r);
        chk_v("rate", r, rate);
        oe_cnt = 0;
        repeat (12) begin
            wr_svc(8'h55);
            wr_svc(8'($urandom) & 8'h7F);
            tick($urandom_range(20));
            wr_svc(8'hAA);
        end
        chk_v("serviced", 0, oe_cnt);
        wr_svc(8'hAA);
        wr_svc(8'h55);
        seq(CAUSE_WD, 5000);
        n = n + 5 - (BASE << 2 * r);
        chk_v("timeout", 1, n inside {[0:3]});
        chk_v("rate reset", 0, rate);
        dis = 1;
        seq(CAUSE_WD, 40);
        chk_v("enabled", 0, wden);
        oe_cnt = 0;
        tick(200);
        chk_v("disabled", 0, oe_cnt);
        hold = 1;
        seq(CAUSE_PIN, 20);
        tick(64);
        wr_rate(2'h3);
        chk_v("late rate", 0, rate);
        clkmon = 1;
        seq(CAUSE_CLKMON, 20);
        dis = 0;
        por(1, 0);
        chk_v("por cycles", 4064, n);
        chk_v("inhibit", 1, inh);
        oe_cnt = 0;
        tick(100);
        chk_v("inhibited", 0, oe_cnt);
        idat = 0;
        iwr = 1;
        tick(1);
        iwr = 0;
        seq(CAUSE_WD, 300);
        end_of_test();
    end
endmodule
bind reset_sequencer reset_sequencer_chk i_chk (
    .i_ref_clk, .i_rst, .i_reset_pin_n, .i_rate_wr, .o_reset_pin_o,
    .o_reset_pin_oe, .o_cpu_reset, .o_reset_vector, .o_reset_cause,
    .o_watchdog_rate_select
);
`default_nettype wire
